// ### design/vcg_pkg.sv
`default_nettype none
package vcg_pkg;

	////////////////////////////////////////////////////////////////////////
	// timing
	localparam int CLK_HZ = 40_000_000; // system clock rate
	localparam int SAMPLE_RATE_HZ = 8_000; // pcm sample rate
	localparam int SAMPLE_CYCLES = CLK_HZ / SAMPLE_RATE_HZ;
	localparam int OSR = 125; // modulator bits per pcm sample
	localparam int CIC_SHIFT = 8; // cic gain 125^3 scaled into 14 bits
	localparam int HPF_SHIFT = 5; // pole at 1 - 2^-5
	localparam int HPF_FRAC = 6; // fraction bits kept in the filter state

	////////////////////////////////////////////////////////////////////////
	// sample and gain formats
	localparam int PCM_W = 14;
	localparam int COEF_W = 9;
	localparam int COEF_FRAC = 5;
	localparam int WIDE_W = 24;
	localparam logic [COEF_W-1:0] COEF_UNITY = 9'h020;
	localparam logic [COEF_W-1:0] COEF_OFF = 9'h000;
	localparam logic signed [PCM_W-1:0] PCM_MAX = 14'h1fff;
	localparam logic signed [PCM_W-1:0] PCM_MIN = 14'h2000;

	////////////////////////////////////////////////////////////////////////
	// register map, byte addresses
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_ANALOG = 4'h4;
	localparam logic [3:0] REG_STATUS = 4'h8;
	localparam logic [3:0] REG_REC_DATA = 4'hc;
	localparam int CTRL_W = 15;
	localparam logic [31:0] CTRL_RESET = 32'h0000_4000;
	localparam int MIC_GAIN_LSB = 0;
	localparam int OUT_GAIN_LSB = 8;
	localparam logic [4:0] MIC_GAIN_MAX = 5'h10;
	localparam logic [3:0] OUT_GAIN_MAX = 4'ha;
	localparam logic [4:0] MIC_GAIN_RESET = 5'h00;
	localparam logic [3:0] OUT_GAIN_RESET = 4'h8;
	localparam int ST_REC_SAT = 0;
	localparam int ST_PLAY_SAT = 1;
	localparam int ST_REC_READY = 2;

	// control fields, bit 14 down to bit 0
	typedef struct packed {
		logic hpf_en;
		logic [1:0] st_path;
		logic [3:0] st_att;
		logic [3:0] dac_gain;
		logic [3:0] adc_gain;
	} vcg_ctrl_s;

	typedef logic signed [PCM_W-1:0] vcg_pcm_t;

	// dB ladder from -24 to +21.5 in 1/32 units
	function automatic logic [COEF_W-1:0] gain_ladder(input logic [3:0] k);
		logic [COEF_W-1:0] c;
		c = COEF_OFF;
		unique case (k)
			4'h0: c = 9'h002;
			4'h1: c = 9'h003;
			4'h2: c = 9'h004;
			4'h3: c = 9'h006;
			4'h4: c = 9'h008;
			4'h5: c = 9'h00c;
			4'h6: c = 9'h010;
			4'h7: c = 9'h018;
			4'h8: c = 9'h020;
			4'h9: c = 9'h030;
			4'ha: c = 9'h040;
			4'hb: c = 9'h060;
			4'hc: c = 9'h080;
			4'hd: c = 9'h0c0;
			4'he: c = 9'h100;
			4'hf: c = 9'h180;
		endcase
		return c;
	endfunction

	// adc and dac code: 0 unity, 1..7 boost, 8..15 cut
	function automatic logic [COEF_W-1:0] path_coef(input logic [3:0] code);
		return gain_ladder({~code[3], code[2:0]});
	endfunction

	// side-tone code: 0 off, 1..15 from -24 dB
	function automatic logic [COEF_W-1:0] sidetone_coef(input logic [3:0] code);
		return (code == 4'h0) ? COEF_OFF : gain_ladder(code - 4'h1);
	endfunction

	function automatic logic signed [WIDE_W-1:0] sext(input vcg_pcm_t v);
		return {{(WIDE_W-PCM_W){v[PCM_W-1]}}, v};
	endfunction

	// clamp a wide value into the 14-bit signed range
	function automatic vcg_pcm_t pcm_sat(input logic signed [WIDE_W-1:0] v);
		if (v > sext(PCM_MAX))
			return PCM_MAX;
		else if (v < sext(PCM_MIN))
			return PCM_MIN;
		else
			return v[PCM_W-1:0];
	endfunction

	function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
			if (be[i])
				r[i*8 +: 8] = wd[i*8 +: 8];
		return r;
	endfunction

endpackage
`default_nettype wire

// ### design/vcg_gain.sv
`timescale 1ns/1ps
`default_nettype none
module vcg_gain
(
	input wire logic clock,
	input wire logic rst,
	input wire logic in_valid,
	input wire vcg_pkg::vcg_pcm_t in_data,
	input wire logic [vcg_pkg::COEF_W-1:0] coef,
	output logic out_valid,
	output vcg_pkg::vcg_pcm_t out_data,
	output logic out_sat
);
	import vcg_pkg::*;

	logic signed [WIDE_W-1:0] prod;
	logic signed [WIDE_W-1:0] scaled;

	// multiply by unsigned coefficient, drop fraction
	always_comb
	begin
		prod = sext(in_data) * $signed({{(WIDE_W-COEF_W){1'b0}}, coef});
		scaled = prod >>> COEF_FRAC;
	end

	// registered, saturated result
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			out_valid <= 1'b0;
			out_data <= '0;
			out_sat <= 1'b0;
		end
		else
		begin
			out_valid <= in_valid;
			out_sat <= in_valid && (scaled != sext(pcm_sat(scaled)));
			if (in_valid)
				out_data <= pcm_sat(scaled);
		end
	end

endmodule
`default_nettype wire

// ### design/vcg_cic.sv
`timescale 1ns/1ps
`default_nettype none
module vcg_cic
#(
	parameter int SHIFT = vcg_pkg::CIC_SHIFT
)
(
	input wire logic clock,
	input wire logic rst,
	input wire logic bit_valid,
	input wire logic bit_in,
	input wire logic dump,
	output logic out_valid,
	output vcg_pkg::vcg_pcm_t out_data
);
	import vcg_pkg::*;

	localparam int ORDER = 3; // one above the modulator order
	logic signed [WIDE_W-1:0] integ_reg [ORDER];
	logic signed [WIDE_W-1:0] delay_reg [ORDER];
	logic signed [WIDE_W-1:0] comb_val [ORDER+1];

	// comb chain evaluated at the dump instant
	always_comb
	begin
		comb_val[0] = integ_reg[ORDER-1];
		for (int i = 0; i < ORDER; i++)
			comb_val[i+1] = comb_val[i] - delay_reg[i];
	end

	// integrators run at the modulator bit rate, wrap is harmless
	always_ff @(posedge clock)
	begin
		if (rst)
			for (int i = 0; i < ORDER; i++)
				integ_reg[i] <= '0;
		else if (bit_valid)
		begin
			integ_reg[0] <= integ_reg[0] + (bit_in ? 24'sh00_0001 : -24'sh00_0001);
			for (int i = 1; i < ORDER; i++)
				integ_reg[i] <= integ_reg[i] + integ_reg[i-1];
		end
	end

	// combs run at the pcm rate
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			for (int i = 0; i < ORDER; i++)
				delay_reg[i] <= '0;
			out_valid <= 1'b0;
			out_data <= '0;
		end
		else
		begin
			out_valid <= dump;
			if (dump)
			begin
				for (int i = 0; i < ORDER; i++)
					delay_reg[i] <= comb_val[i];
				out_data <= pcm_sat(comb_val[ORDER] >>> SHIFT);
			end
		end
	end

endmodule
`default_nettype wire

// ### design/vcg_codec_top.sv
// Overview of operation
// RULE1 - record and playback words are 14-bit linear pcm at 8 kHz
// RULE2 - delta-sigma bitstream decimated to 14-bit pcm at 8 kHz
// RULE3 - side-tone code 0 off, codes 1..15 give -24 to 18 dB
// RULE4 - two-bit path code picks tap A or B and injection C or D
// RULE5 - adc gain code 0..7 boosts to 21.5 dB, 8..15 cuts from -24
// RULE6 - dac gain uses the same coding as the adc gain
// RULE7 - bass-cut high-pass filter at the end of the record chain; here it sits between the decimator and the adc gain
// RULE8 - enabled side tone adds attenuated microphone signal to playback
// RULE9 - microphone input gain spans 50 dB in 3 dB steps
// RULE10 - output gain from -24 to +6 dB in 3 dB steps
// RULE11 - side-tone plus playback sum saturates to 14-bit signed range
//
// The implementer's own choices: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module vcg_codec_top
#(
	parameter int SAMPLE_CYCLES_P = vcg_pkg::SAMPLE_CYCLES,
	parameter int OSR_P = vcg_pkg::OSR
)
(
	input wire logic clock,
	input wire logic rst,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output logic adc_mod_strobe,
	input wire logic adc_bit,
	output vcg_pkg::vcg_pcm_t dac_data,
	output logic dac_valid,
	output logic [4:0] microphone_input_gain,
	output logic [3:0] output_gain,
	output vcg_pkg::vcg_pcm_t rec_data,
	output logic rec_valid,
	input wire vcg_pkg::vcg_pcm_t play_data,
	output logic play_taken
);
	import vcg_pkg::*;

	localparam int MOD_CYC = SAMPLE_CYCLES_P / OSR_P;
	localparam int MW = $clog2(MOD_CYC + 1);
	localparam int BW = $clog2(OSR_P + 1);

	////////////////////////////////////////////////////////////////////////
	// declarations
	logic [MW-1:0] mod_cnt_reg;
	logic [BW-1:0] bit_cnt_reg;
	logic tick;
	vcg_ctrl_s ctrl_reg;
	logic [4:0] mic_gain_reg;
	logic [3:0] out_gain_reg;
	logic rec_sat_reg;
	logic play_sat_reg;
	logic rec_ready_reg;
	logic ack_reg;
	logic [31:0] rdata_reg;
	logic req;
	logic done;
	logic [31:0] ctrl_word;
	logic [31:0] analog_word;
	logic [31:0] status_word;
	logic [31:0] merged;
	logic dec_valid;
	vcg_pcm_t dec_data;
	logic signed [WIDE_W-1:0] hpf_y_reg;
	logic signed [WIDE_W-1:0] hpf_y_next;
	vcg_pcm_t hpf_x1_reg;
	vcg_pcm_t hpf_out_reg;
	logic hpf_valid_reg;
	logic adcg_valid;
	vcg_pcm_t adcg_out;
	logic adcg_sat;
	vcg_pcm_t play_reg;
	logic st_in_valid;
	vcg_pcm_t st_in;
	logic st_valid;
	vcg_pcm_t st_out;
	logic st_sat;
	logic signed [WIDE_W-1:0] sum_c;
	logic signed [WIDE_W-1:0] sum_d;
	vcg_pcm_t dg_in;
	logic dg_valid;
	vcg_pcm_t dg_out;
	logic dg_sat;
	logic c_ovf;
	logic d_ovf;
	vcg_pcm_t dac_data_reg;
	logic dac_valid_reg;
	logic [4:0] mic_wr;
	logic [3:0] out_wr;

	////////////////////////////////////////////////////////////////////////
	// sample timing: modulator bit strobe and 8 kHz tick
	assign adc_mod_strobe = (mod_cnt_reg == MW'(MOD_CYC - 1));
	assign tick = adc_mod_strobe && (bit_cnt_reg == BW'(OSR_P - 1)); // RULE1
	assign play_taken = tick;

	// modulator bit-period counter
	always_ff @(posedge clock)
	begin
		if (rst || adc_mod_strobe)
			mod_cnt_reg <= '0;
		else
			mod_cnt_reg <= mod_cnt_reg + MW'(1);
	end

	// bits per pcm sample
	always_ff @(posedge clock)
	begin
		if (rst || tick)
			bit_cnt_reg <= '0;
		else if (adc_mod_strobe)
			bit_cnt_reg <= bit_cnt_reg + BW'(1);
	end

	////////////////////////////////////////////////////////////////////////
	// record path: decimator, bass cut, adc gain
	vcg_cic u_cic
	(
		.clock(clock),
		.rst(rst),
		.bit_valid(adc_mod_strobe),
		.bit_in(adc_bit),
		.dump(tick),
		.out_valid(dec_valid),
		.out_data(dec_data)
	); // RULE2

	// first-order dc blocker, state keeps fraction bits
	always_comb
	begin
		hpf_y_next = ((sext(dec_data) - sext(hpf_x1_reg)) <<< HPF_FRAC)
			+ hpf_y_reg - (hpf_y_reg >>> HPF_SHIFT); // RULE7
	end

	// filter state and output, bypass when disabled
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			hpf_y_reg <= '0;
			hpf_x1_reg <= '0;
			hpf_out_reg <= '0;
			hpf_valid_reg <= 1'b0;
		end
		else
		begin
			hpf_valid_reg <= dec_valid;
			if (dec_valid)
			begin
				hpf_x1_reg <= dec_data;
				hpf_y_reg <= ctrl_reg.hpf_en ? hpf_y_next : '0;
				hpf_out_reg <= ctrl_reg.hpf_en ? pcm_sat(hpf_y_next >>> HPF_FRAC) : dec_data; // RULE7
			end
		end
	end

	vcg_gain u_adc_gain
	(
		.clock(clock),
		.rst(rst),
		.in_valid(hpf_valid_reg),
		.in_data(hpf_out_reg),
		.coef(path_coef(ctrl_reg.adc_gain)), // RULE5
		.out_valid(adcg_valid),
		.out_data(adcg_out),
		.out_sat(adcg_sat)
	);

	assign rec_valid = adcg_valid;
	assign rec_data = adcg_out;

	////////////////////////////////////////////////////////////////////////
	// side tone: A taps before adc gain, B after it
	assign st_in_valid = ctrl_reg.st_path[0] ? adcg_valid : hpf_valid_reg; // RULE4
	assign st_in = ctrl_reg.st_path[0] ? adcg_out : hpf_out_reg; // RULE4

	vcg_gain u_st_gain
	(
		.clock(clock),
		.rst(rst),
		.in_valid(st_in_valid),
		.in_data(st_in),
		.coef(sidetone_coef(ctrl_reg.st_att)), // RULE3
		.out_valid(st_valid),
		.out_data(st_out),
		.out_sat(st_sat)
	);

	// playback word latched on the tick
	always_ff @(posedge clock)
	begin
		if (rst)
			play_reg <= '0;
		else if (tick)
			play_reg <= play_data; // RULE1
	end

	// C injects before dac gain, D after it
	always_comb
	begin
		sum_c = sext(play_reg) + sext(st_out); // RULE8
		sum_d = sext(dg_out) + sext(st_out); // RULE8
		c_ovf = sum_c != sext(pcm_sat(sum_c));
		d_ovf = sum_d != sext(pcm_sat(sum_d));
		dg_in = ctrl_reg.st_path[1] ? play_reg : pcm_sat(sum_c); // RULE11
	end

	vcg_gain u_dac_gain
	(
		.clock(clock),
		.rst(rst),
		.in_valid(st_valid),
		.in_data(dg_in),
		.coef(path_coef(ctrl_reg.dac_gain)), // RULE6
		.out_valid(dg_valid),
		.out_data(dg_out),
		.out_sat(dg_sat)
	);

	// final dac word
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			dac_data_reg <= '0;
			dac_valid_reg <= 1'b0;
		end
		else
		begin
			dac_valid_reg <= dg_valid;
			if (dg_valid)
				dac_data_reg <= ctrl_reg.st_path[1] ? pcm_sat(sum_d) : dg_out; // RULE11
		end
	end

	assign dac_data = dac_data_reg;
	assign dac_valid = dac_valid_reg;

	////////////////////////////////////////////////////////////////////////
	// avalon slave, one wait state on every access
	assign req = avs_read || avs_write;
	assign avs_waitrequest = req && !ack_reg;
	assign done = req && ack_reg;
	assign avs_readdata = rdata_reg;
	assign ctrl_word = {{(32-CTRL_W){1'b0}}, ctrl_reg};
	assign analog_word = {20'h0_0000, out_gain_reg, 3'h0, mic_gain_reg};
	assign status_word = {29'h0000_0000, rec_ready_reg, play_sat_reg, rec_sat_reg};
	assign merged = be_merge((avs_address == REG_CTRL) ? ctrl_word : analog_word,
		avs_writedata, avs_byteenable);
	assign mic_wr = merged[MIC_GAIN_LSB +: 5];
	assign out_wr = merged[OUT_GAIN_LSB +: 4];
	assign microphone_input_gain = mic_gain_reg;
	assign output_gain = out_gain_reg;

	// wait-state flag
	always_ff @(posedge clock)
	begin
		if (rst)
			ack_reg <= 1'b0;
		else
			ack_reg <= req && !ack_reg;
	end

	// read data captured in the wait cycle
	always_ff @(posedge clock)
	begin
		if (rst)
			rdata_reg <= '0;
		else if (avs_read && !ack_reg)
		begin
			unique case (avs_address)
				REG_CTRL: rdata_reg <= ctrl_word;
				REG_ANALOG: rdata_reg <= analog_word;
				REG_STATUS: rdata_reg <= status_word;
				REG_REC_DATA: rdata_reg <= {18'h0_0000, adcg_out};
				default: rdata_reg <= '0;
			endcase
		end
	end

	// control register
	always_ff @(posedge clock)
	begin
		if (rst)
			ctrl_reg <= vcg_ctrl_s'(CTRL_RESET[CTRL_W-1:0]);
		else if (done && avs_write && avs_address == REG_CTRL)
			ctrl_reg <= vcg_ctrl_s'(merged[CTRL_W-1:0]);
	end

	// analogue gain codes, out-of-range writes clamp
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			mic_gain_reg <= MIC_GAIN_RESET;
			out_gain_reg <= OUT_GAIN_RESET;
		end
		else if (done && avs_write && avs_address == REG_ANALOG)
		begin
			mic_gain_reg <= (mic_wr > MIC_GAIN_MAX) ? MIC_GAIN_MAX : mic_wr; // RULE9
			out_gain_reg <= (out_wr > OUT_GAIN_MAX) ? OUT_GAIN_MAX : out_wr; // RULE10
		end
	end

	// sticky status, a set beats a clear in the same cycle
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			rec_sat_reg <= 1'b0;
			play_sat_reg <= 1'b0;
			rec_ready_reg <= 1'b0;
		end
		else
		begin
			if (adcg_sat)
				rec_sat_reg <= 1'b1;
			else if (done && avs_write && avs_address == REG_STATUS && avs_byteenable[0]
				&& avs_writedata[ST_REC_SAT])
				rec_sat_reg <= 1'b0;
			if (dg_sat || st_sat || (st_valid && c_ovf && !ctrl_reg.st_path[1])
				|| (dg_valid && d_ovf && ctrl_reg.st_path[1]))
				play_sat_reg <= 1'b1;
			else if (done && avs_write && avs_address == REG_STATUS && avs_byteenable[0]
				&& avs_writedata[ST_PLAY_SAT])
				play_sat_reg <= 1'b0;
			if (adcg_valid)
				rec_ready_reg <= 1'b1;
			else if (done && avs_read && avs_address == REG_REC_DATA)
				rec_ready_reg <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	logic [15:0] gap_reg;
	logic seen_reg;

	// cycles since the last record word
	always_ff @(posedge clock)
	begin
		if (rst || rec_valid)
			gap_reg <= '0;
		else
			gap_reg <= gap_reg + 16'h0001;
	end

	always_ff @(posedge clock)
	begin
		if (rst)
			seen_reg <= 1'b0;
		else if (rec_valid)
			seen_reg <= 1'b1;
	end

	sequence s_rec_chain;
		dec_valid ##1 hpf_valid_reg ##1 adcg_valid;
	endsequence

	a_pcm_rate: assert property (rec_valid && seen_reg |-> gap_reg == 16'(SAMPLE_CYCLES_P - 1)) // RULE1
		else $error("record words not spaced at the sample period");
	a_decim_chain: assert property (tick |=> s_rec_chain) // RULE2
		else $error("record chain did not follow the tick");
	a_st_off_zero: assert property (st_valid && $past(ctrl_reg.st_att) == 4'h0 |-> st_out == '0) // RULE3
		else $error("side tone not silent when off");
	a_st_tap_sel: assert property (st_valid && $past(ctrl_reg.st_att) == 4'h9 // RULE4
		|-> st_out == ($past(ctrl_reg.st_path[0]) ? $past(adcg_out) : $past(hpf_out_reg)))
		else $error("side-tone tap not the selected source");
	a_adc_unity: assert property (rec_valid && $past(ctrl_reg.adc_gain) == 4'h0 // RULE5
		|-> rec_data == hpf_out_reg)
		else $error("0 dB adc gain changed the sample");
	a_dac_unity: assert property (dg_valid && $past(ctrl_reg.dac_gain) == 4'h0 // RULE6
		|-> dg_out == $past(dg_in))
		else $error("0 dB dac gain changed the sample");
	a_hpf_bypass: assert property (hpf_valid_reg && !$past(ctrl_reg.hpf_en) // RULE7
		|-> hpf_out_reg == $past(dec_data))
		else $error("bass cut bypass altered the sample");
	a_st_inject_c: assert property (dg_valid && !$past(ctrl_reg.st_path[1]) // RULE8
		&& $past(ctrl_reg.dac_gain) == 4'h0
		|-> dg_out == pcm_sat(sext($past(play_reg)) + sext($past(st_out))))
		else $error("side tone not injected ahead of dac gain");
	a_mic_range: assert property (microphone_input_gain <= MIC_GAIN_MAX) // RULE9
		else $error("microphone gain code beyond 50 dB");
	a_out_range: assert property (output_gain <= OUT_GAIN_MAX) // RULE10
		else $error("output gain code beyond +6 dB");
	a_sum_no_wrap: assert property (dg_valid && ctrl_reg.st_path[1] && !dg_out[PCM_W-1] // RULE11
		&& !st_out[PCM_W-1] |=> !dac_data[PCM_W-1])
		else $error("side-tone sum wrapped negative");
	a_bus_one_wait: assert property (req && !ack_reg |=> !req || !avs_waitrequest)
		else $error("bus access took more than one wait state");

endmodule
`default_nettype wire

// ### test/vcg_front_end.sv
`timescale 1ns/1ps
`default_nettype none
module vcg_front_end
(
	input wire logic clock,
	input wire logic rst,
	input wire logic adc_mod_strobe,
	input wire logic signed [31:0] level,
	output logic adc_bit = 1'b1,
	input wire logic dac_valid,
	output int dac_count
);
	import vcg_pkg::*;
	int i1;
	int i2;
	int fb;

	////////////////////////////////////////////////////////////////////////
	// second-order modulator, next bit prepared after each strobe
	always @(posedge clock)
	begin
		fb = adc_bit ? 1024 : -1024;
		if (rst || level >= 1024 || level <= -1024)
		begin
			i1 = 0;
			i2 = 0;
			adc_bit <= (level > 0); // full scale holds the stream constant
		end
		else if (adc_mod_strobe)
		begin
			i1 = i1 + level - fb;
			i2 = i2 + i1 - fb;
			adc_bit <= (i2 >= 0);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// speaker side counts the words it is handed
	always @(posedge clock)
	begin
		if (rst)
			dac_count <= 0;
		else if (dac_valid)
			dac_count <= dac_count + 1;
	end
endmodule
`default_nettype wire

// ### test/vcg_codec_top_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin check_count++; if ((got) !== (exp)) begin mismatches++; \
	$display("[ERR] %s expected %0d seen %0d", nm, exp, got); end end
module vcg_codec_top_tb_top;
	import vcg_pkg::*;
	localparam int SC = 250;
	localparam int OS = 25;
	localparam int LAD [16] = '{2, 3, 4, 6, 8, 12, 16, 24, 32, 48, 64, 96, 128, 192, 256, 384};
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic [3:0] avs_address = 4'h0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0000_0000;
	logic [3:0] avs_byteenable = 4'hf;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic adc_mod_strobe;
	logic adc_bit;
	vcg_pcm_t dac_data;
	logic dac_valid;
	logic [4:0] microphone_input_gain;
	logic [3:0] output_gain;
	vcg_pcm_t rec_data;
	logic rec_valid;
	vcg_pcm_t play_data = 14'h0000;
	logic play_taken;
	int mismatches = 0;
	int check_count = 0;
	int lvl = 1024;
	int adc_c, dac_c, st_c, path_c, play_fix, last_play, dac_count;
	int gap = -1;
	bit hpf_on = 1'b1;
	bit chk_en = 1'b0;
	bit seeded = 1'b0;
	logic [31:0] q;

	initial
		forever #12.5 clock = ~clock;

	vcg_codec_top #(.SAMPLE_CYCLES_P(SC), .OSR_P(OS)) i_dut (.clock(clock), .rst(rst),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.adc_mod_strobe(adc_mod_strobe), .adc_bit(adc_bit), .dac_data(dac_data),
		.dac_valid(dac_valid), .microphone_input_gain(microphone_input_gain),
		.output_gain(output_gain), .rec_data(rec_data), .rec_valid(rec_valid),
		.play_data(play_data), .play_taken(play_taken));

	vcg_front_end i_fe (.clock(clock), .rst(rst), .adc_mod_strobe(adc_mod_strobe), .level(lvl),
		.adc_bit(adc_bit), .dac_valid(dac_valid), .dac_count(dac_count));

	////////////////////////////////////////////////////////////////////////
	// integer model of the datapath
	function automatic int sat14(input int v);
		return (v > 8191) ? 8191 : ((v < -8192) ? -8192 : v);
	endfunction
	function automatic int gain(input int x, input int c);
		return sat14((x * c) >>> 5);
	endfunction
	function automatic int dec_val();
		return ((lvl > 0) ? OS * OS * OS : -OS * OS * OS) >>> CIC_SHIFT;
	endfunction
	function automatic int exp_rec();
		return gain(dec_val(), LAD[adc_c ^ 8]);
	endfunction
	function automatic int exp_st();
		if (st_c == 0)
			return 0;
		return gain((path_c % 2) ? exp_rec() : dec_val(), LAD[st_c - 1]);
	endfunction
	function automatic int exp_dac();
		if (path_c < 2)
			return gain(sat14(last_play + exp_st()), LAD[dac_c ^ 8]);
		return sat14(gain(last_play, LAD[dac_c ^ 8]) + exp_st());
	endfunction

	////////////////////////////////////////////////////////////////////////
	// playback feed, record word spacing checked always, and comparison of results while chk_en is set (record data only with the bass cut off)
	always @(posedge clock)
	begin
		if (!seeded)
		begin
			seeded = 1'b1;
			void'($urandom(32'hf49865c9));
		end
		if (play_taken === 1'b1)
		begin
			last_play = play_data;
			play_data <= (play_fix != 0) ? play_fix[13:0] : 14'($urandom);
		end
		if (rec_valid === 1'b1)
		begin
			if (gap >= 0)
				`CHK("rec_gap", SC, gap)
			gap = 1;
			if (chk_en && !hpf_on)
				`CHK("rec_data", exp_rec(), rec_data)
		end
		else if (gap >= 0)
			gap++;
		if (dac_valid === 1'b1 && chk_en)
			`CHK("dac_data", exp_dac(), dac_data)
	end

	////////////////////////////////////////////////////////////////////////
	// bus master, holds the request until waitrequest is seen low
	task automatic bus(input bit wr, input logic [3:0] a, input logic [31:0] d);
		int n;
		n = 0;
		avs_address <= a;
		avs_writedata <= d;
		avs_read <= !wr;
		avs_write <= wr;
		@(posedge clock);
		while (avs_waitrequest !== 1'b0 && n < 50)
		begin
			n++;
			@(posedge clock);
		end
		// waitrequest seen low at this edge: data taken, request released
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		if (n >= 50)
			mismatches++;
		// idle edge so the next call never reassigns in this time step
		@(posedge clock);
	endtask

	task automatic setup(input int a, input int dc, input int st, input int p, input bit h);
		adc_c = a;
		dac_c = dc;
		st_c = st;
		path_c = p;
		hpf_on = h;
		bus(1'b1, REG_CTRL, 32'hffff_8000 | {h, p[1:0], st[3:0], dc[3:0], a[3:0]});
		bus(1'b0, REG_CTRL, 32'h0000_0000);
		`CHK("ctrl", {17'h0, h, p[1:0], st[3:0], dc[3:0], a[3:0]}, q)
	endtask

	task automatic settle(input int n);
		chk_en <= 1'b0;
		repeat (4 * SC) @(posedge clock);
		chk_en <= 1'b1;
		repeat (n * SC) @(posedge clock);
		chk_en <= 1'b0;
	endtask

	task automatic final_report();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	// watchdog against a hung handshake
	initial
	begin
		repeat (70000) @(posedge clock);
		mismatches++;
		final_report();
	end

	////////////////////////////////////////////////////////////////////////
	// main sequence
	initial
	begin
		repeat (12) @(posedge clock);
		rst <= 1'b0;
		bus(1'b0, REG_CTRL, 32'h0000_0000);
		`CHK("ctrl_rst", 32'h0000_4000, q)
		bus(1'b0, REG_ANALOG, 32'h0000_0000);
		`CHK("analog_rst", 32'h0000_0800, q)
		`CHK("out_gain_rst", 4'h8, output_gain)
		`CHK("mic_gain_rst", 5'h00, microphone_input_gain)
		$display("test reset done");
		bus(1'b1, REG_ANALOG, 32'h0000_0f1f);
		bus(1'b0, REG_ANALOG, 32'h0000_0000);
		`CHK("analog_clamp", 32'h0000_0a10, q)
		`CHK("out_gain_max", 4'ha, output_gain)
		`CHK("mic_gain_max", 5'h10, microphone_input_gain)
		bus(1'b1, REG_ANALOG, 32'h0000_0507);
		`CHK("out_gain_mid", 4'h5, output_gain)
		`CHK("mic_gain_mid", 5'h07, microphone_input_gain)
		$display("test analogue gains done");
		// every gain, attenuation and path code, both input polarities
		for (int i = 0; i < 16; i++)
		begin
			lvl <= (i % 2) ? -1024 : 1024;
			setup(i, (i + 5) % 16, i, i % 4, 1'b0);
			settle(1);
			bus(1'b0, REG_REC_DATA, 32'h0000_0000);
			`CHK("rec_reg", {18'h0, 14'(exp_rec())}, q)
		end
		$display("test code sweep done");
		// sum of side tone and playback clamps at both ends
		play_fix = 8180;
		lvl <= 1024;
		setup(0, 0, 9, 0, 1'b0);
		settle(2);
		`CHK("dac_sat_hi", 8191, dac_data)
		play_fix = -8190;
		lvl <= -1024;
		settle(2);
		`CHK("dac_sat_lo", -8192, dac_data)
		bus(1'b0, REG_STATUS, 32'h0000_0000);
		`CHK("play_sat_flag", 1'b1, q[ST_PLAY_SAT])
		play_fix = 0;
		$display("test saturation done");
		// bass cut passes a step, then removes the steady level
		setup(0, 0, 0, 0, 1'b1);
		lvl <= 1024;
		repeat (6 * SC) @(posedge clock);
		`CHK("hpf_step", 1'b1, rec_data > 14'sd50)
		repeat (124 * SC) @(posedge clock);
		`CHK("hpf_small", 1'b1, (rec_data < 14'sd5) && (rec_data > -14'sd5))
		`CHK("dac_words", 1'b1, dac_count > 20)
		$display("test bass cut done");
		final_report();
	end
endmodule
`default_nettype wire
